//--- phy_pd_pkg.sv
package phy_pd_pkg;

	// ---------------------------------------------------------------
	// geometry and timing
	// ---------------------------------------------------------------
	localparam int NUM_PORTS = 2;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ED_PULSE_NS = 100;
	localparam int ED_PULSE_CYC = (ED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ED_WAKE_DEF = 250000; // cycles between wake pulses, plain default
	localparam int ED_CNT_W = 20;
	localparam int POL_RUN = 3; // inverted link pulses in a row
	localparam logic [1:0] POL_LAST = 2'(POL_RUN - 1);

	// ---------------------------------------------------------------
	// register offsets and pages
	// ---------------------------------------------------------------
	localparam logic [4:0] OFS_BASIC_MODE_CONTROL = 5'h00;
	localparam logic [4:0] OFS_PHY_STATUS_SUMMARY = 5'h10;
	localparam logic [4:0] OFS_IRQ_CONTROL = 5'h11;
	localparam logic [4:0] OFS_IRQ_STATUS_AND_MASK = 5'h12;
	localparam logic [4:0] OFS_REGISTER_PAGE_SELECT = 5'h13;
	localparam logic [4:0] OFS_TENBASE_STATUS_CONTROL = 5'h1a;
	localparam logic [4:0] OFS_ENERGY_DETECT_CONTROL = 5'h1d;
	localparam logic [2:0] PAGE_MAIN = 3'h0;
	localparam logic [2:0] PAGE_DIAG = 3'h2;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BASIC_MODE_CONTROL_PD_BIT = 11;
	localparam int IRQ_CONTROL_OE_BIT = 0;
	localparam int IRQ_CONTROL_EN_BIT = 1;
	localparam int PHY_STATUS_SUMMARY_LINK_BIT = 0;
	localparam int PHY_STATUS_SUMMARY_SPD10_BIT = 1;
	localparam int PHY_STATUS_SUMMARY_IRQ_BIT = 7;
	localparam int PHY_STATUS_SUMMARY_POL_BIT = 12;
	localparam int TBS_POL_BIT = 4;
	localparam int ENERGY_DETECT_CONTROL_EN_BIT = 15;
	localparam int IRQ_LINK_IDX = 5;
	localparam int IRQ_ED_IDX = 6;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] BASIC_MODE_CONTROL_RST = 16'h0000;
	localparam logic [15:0] TBS_RST = 16'h0000;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] PEND_RST = 8'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ED_AWAKE, ED_SLEEP, ED_PULSE} ed_state_t;

	typedef struct packed {
		logic [15:0] basic_mode_control;
		logic int_oe;
		logic irq_en;
		logic [7:0] mask;
		logic [7:0] pend;
		logic [2:0] page;
		logic [15:0] tbs;
		logic ed_en;
		ed_state_t ed;
		logic [ED_CNT_W-1:0] ed_cnt;
	} port_state_t;

	typedef struct packed {
		port_state_t [NUM_PORTS-1:0] port;
		logic [15:0] rdata;
	} core_state_t;

	typedef struct packed {
		logic meta;
		logic held;
	} sync_state_t;

	typedef struct packed {
		logic [1:0] inv_run;
		logic [1:0] ok_run;
		logic bad;
		logic invert;
	} pol_state_t;

endpackage

//--- sense_if.sv
`timescale 1ns/10ps
// per-port pin sense and link polarity signals between the core and its helpers
interface sense_if;
	logic pin_raw;
	logic pin_sync;
	logic nlp_pulse;
	logic nlp_inv;
	logic rd_clear;
	logic bad_pol;
	logic pol_invert;

	modport sync_mp (input pin_raw, output pin_sync);
	modport pol_mp (input nlp_pulse, input nlp_inv, input rd_clear,
		output bad_pol, output pol_invert);
	modport core_mp (output pin_raw, input pin_sync, output nlp_pulse, output nlp_inv,
		output rd_clear, input bad_pol, input pol_invert);
endinterface

//--- pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for the shared pin input
module pin_sync
	import phy_pd_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// sense signals
	sense_if.sync_mp sif
);

	sync_state_t q;
	sync_state_t d;

	// meta stage feeds only the held stage
	always_comb
	begin
		d = q;
		d.meta = sif.pin_raw;
		d.held = q.meta;
	end

	// idle level is high, as the pull-up leaves it
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '{meta: 1'b1, held: 1'b1};
		else
			q <= d;
	end

	assign sif.pin_sync = q.held;

endmodule

//--- polarity_detect.sv
`timescale 1ns/10ps
// link pulse polarity detector with latched report and internal correction
module polarity_detect
	import phy_pd_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// sense signals
	sense_if.pol_mp sif
);

	pol_state_t q;
	pol_state_t d;

	// count runs of inverted and normal pulses
	always_comb
	begin
		d = q;
		d.bad = q.bad & ~sif.rd_clear;
		if (sif.nlp_pulse)
		begin
			if (sif.nlp_inv)
			begin
				d.ok_run = 2'h0;
				if (q.inv_run == POL_LAST)
				begin
					d.bad = 1'b1; // set wins over read clear
					d.invert = 1'b1; // receiver swaps the pair itself
				end
				else
					d.inv_run = q.inv_run + 2'h1;
			end
			else
			begin
				d.inv_run = 2'h0;
				if (q.ok_run == POL_LAST)
					d.invert = 1'b0;
				else
					d.ok_run = q.ok_run + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '{inv_run: 2'h0, ok_run: 2'h0, bad: 1'b0, invert: 1'b0};
		else
			q <= d;
	end

	assign sif.bad_pol = q.bad;
	assign sif.pol_invert = q.invert;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_pol_three_pulses: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(sif.nlp_pulse && sif.nlp_inv && q.inv_run == POL_LAST) |=> (sif.bad_pol && sif.pol_invert))
		else $error("bad polarity not latched after third inverted pulse");

	chk_pol_latch_holds: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(sif.bad_pol && !sif.rd_clear) |=> sif.bad_pol)
		else $error("bad polarity dropped without a read");

	chk_pol_corrects: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(sif.nlp_pulse && !sif.nlp_inv && q.ok_run == POL_LAST) |=> !sif.pol_invert)
		else $error("correction kept after three normal pulses");

endmodule

//--- phy_pd_irq_core.sv
`timescale 1ns/10ps
// Functional notes
// - shared pin is power-down input after reset
// - irq_control bit 0 makes pin irq output
// - pin low as input powers the port down
// - weak pull-up keeps idle pin high
// - pin strapped low starts port powered down
// - management works powered down; output enable exits
// - each port has its own shared pin
// - every interrupt source disabled after reset
// - global enable and per-source mask gate interrupts
// - pin asserts low asynchronously on enabled event
// - upper status byte shows pending sources
// - status read clears all pending, pin releases
// - 0003h and 0060h writes enable example sources
// - energy detect idles low power, activity wakes
// - low power still sends periodic wake pulses
// - diagnostic page 2 chosen via page select
// - reversed polarity shown in two status registers
// - polarity valid only 10M or autonegotiated 100M
// - receiver corrects polarity; flag is informational
// - three inverted pulses latch bad polarity
module phy_pd_irq_core
	import phy_pd_pkg::*;
#(
	parameter int ED_WAKE_CYCLES = ED_WAKE_DEF
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// management register port
	input wire logic mgmt_port_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic mgmt_wr_i,
	input wire logic mgmt_rd_i,
	input wire logic [15:0] mgmt_wdata_i,
	output logic [15:0] mgmt_rdata_o,
	// shared pin, port a
	input wire logic sleep_or_irq_pin_port_a_i,
	output logic sleep_or_irq_pin_port_a_o,
	output logic sleep_or_irq_pin_port_a_oe_n_o,
	output logic sleep_or_irq_pin_port_a_pullup_o,
	// shared pin, port b
	input wire logic sleep_or_irq_pin_port_b_i,
	output logic sleep_or_irq_pin_port_b_o,
	output logic sleep_or_irq_pin_port_b_oe_n_o,
	output logic sleep_or_irq_pin_port_b_pullup_o,
	// per-port line status, index 0 is port a
	input wire logic [NUM_PORTS-1:0] link_up_i,
	input wire logic [NUM_PORTS-1:0] speed10_i,
	input wire logic [NUM_PORTS-1:0] an100_i,
	input wire logic [NUM_PORTS-1:0] line_energy_i,
	input wire logic [NUM_PORTS-1:0] nlp_pulse_i,
	input wire logic [NUM_PORTS-1:0] nlp_inverted_i,
	input wire logic [NUM_PORTS-1:0][7:0] irq_src_i,
	// per-port controls
	output logic [NUM_PORTS-1:0] power_down_o,
	output logic [NUM_PORTS-1:0] ed_low_power_o,
	output logic [NUM_PORTS-1:0] ed_tx_wake_o,
	output logic [NUM_PORTS-1:0] rx_pol_invert_o
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	localparam logic [ED_CNT_W-1:0] WAKE_LOAD = ED_CNT_W'(ED_WAKE_CYCLES - 1);
	localparam logic [ED_CNT_W-1:0] PULSE_LOAD = ED_CNT_W'(ED_PULSE_CYC - 1);
	localparam port_state_t PORT_RST = '{
		basic_mode_control: BASIC_MODE_CONTROL_RST, int_oe: 1'b0, irq_en: 1'b0, mask: MASK_RST,
		pend: PEND_RST, page: PAGE_MAIN, tbs: TBS_RST, ed_en: 1'b0,
		ed: ED_AWAKE, ed_cnt: '0};

	core_state_t q;
	core_state_t d;
	logic [NUM_PORTS-1:0] pin_in;
	logic [NUM_PORTS-1:0] pin_held;
	logic [NUM_PORTS-1:0] bad_pol;
	logic [NUM_PORTS-1:0] pol_rep;
	logic [NUM_PORTS-1:0] sel;
	logic [NUM_PORTS-1:0] rd_irq_status_and_mask;
	logic [NUM_PORTS-1:0] rd_tbs;
	logic [NUM_PORTS-1:0] ed_wake;
	logic [NUM_PORTS-1:0] ed_sleep;
	logic [NUM_PORTS-1:0] ed_evt;
	logic [NUM_PORTS-1:0] irq_active;
	logic [NUM_PORTS-1:0][7:0] src_now;
	logic [NUM_PORTS-1:0][7:0] armed;

	// register hit: page select is seen on every page, the rest on page 0
	function automatic logic reg_hit(input logic [4:0] addr, input logic [2:0] page,
		input logic [4:0] ofs);
		reg_hit = (addr == ofs) && (ofs == OFS_REGISTER_PAGE_SELECT || page == PAGE_MAIN);
	endfunction

	assign pin_in = {sleep_or_irq_pin_port_b_i, sleep_or_irq_pin_port_a_i};

	// ---------------------------------------------------------------
	// per-port helpers and combinational pin logic
	// ---------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		sense_if sif ();

		// each port owns its pin and sense path
		assign sif.pin_raw = pin_in[p];
		assign sif.nlp_pulse = nlp_pulse_i[p];
		assign sif.nlp_inv = nlp_inverted_i[p];
		assign sif.rd_clear = rd_tbs[p];
		assign pin_held[p] = sif.pin_sync;
		assign bad_pol[p] = sif.bad_pol;
		assign rx_pol_invert_o[p] = sif.pol_invert;

		pin_sync u_sync (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.sif(sif.sync_mp)
		);

		polarity_detect u_pol (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.sif(sif.pol_mp)
		);

		// management decode
		assign sel[p] = (mgmt_port_i == 1'(p));
		assign rd_irq_status_and_mask[p] = mgmt_rd_i && sel[p] &&
			reg_hit(mgmt_addr_i, q.port[p].page, OFS_IRQ_STATUS_AND_MASK);
		assign rd_tbs[p] = mgmt_rd_i && sel[p] &&
			reg_hit(mgmt_addr_i, q.port[p].page, OFS_TENBASE_STATUS_CONTROL);

		// polarity shown only where link pulses carry it
		assign pol_rep[p] = bad_pol[p] & (speed10_i[p] | an100_i[p]);

		// energy detect transitions
		assign ed_wake[p] = line_energy_i[p] | ~q.port[p].ed_en;
		assign ed_sleep[p] = q.port[p].ed_en & ~line_energy_i[p];
		assign ed_evt[p] = (q.port[p].ed == ED_AWAKE) ? ed_sleep[p] : ed_wake[p];

		// sources gated by mask
		assign src_now[p] = irq_src_i[p] | ({7'h00, ed_evt[p]} << IRQ_ED_IDX);
		assign armed[p] = src_now[p] & q.port[p].mask;

		// the live event term lets the pin fall without a clock edge
		assign irq_active[p] = q.port[p].irq_en &
			((|q.port[p].pend) | (|armed[p]));

		// power-down: register bit, or pin low while it is an input
		assign power_down_o[p] = q.port[p].basic_mode_control[BASIC_MODE_CONTROL_PD_BIT] |
			(~q.port[p].int_oe & ~pin_held[p]);

		assign ed_low_power_o[p] = (q.port[p].ed != ED_AWAKE);
		assign ed_tx_wake_o[p] = (q.port[p].ed == ED_PULSE);

		// ---------------------------------------------------------------
		// checks
		// ---------------------------------------------------------------
		chk_pin_input_default: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			!q.port[p].int_oe |-> (p == 0 ? sleep_or_irq_pin_port_a_oe_n_o
				: sleep_or_irq_pin_port_b_oe_n_o))
			else $error("pin driven while configured as input");

		chk_pin_output_on: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(mgmt_wr_i && sel[p] && reg_hit(mgmt_addr_i, q.port[p].page, OFS_IRQ_CONTROL)
				&& mgmt_wdata_i[IRQ_CONTROL_OE_BIT])
			|=> !(p == 0 ? sleep_or_irq_pin_port_a_oe_n_o : sleep_or_irq_pin_port_b_oe_n_o))
			else $error("pin not driven after output enable write");

		chk_pin_powers_down: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			// one extra cycle covers the synchroniser still in reset at release
			(!q.port[p].int_oe && !pin_in[p])[*4] |-> power_down_o[p])
			else $error("pin held low did not power down");

		chk_oe_exits_pd: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			($rose(q.port[p].int_oe) && !q.port[p].basic_mode_control[BASIC_MODE_CONTROL_PD_BIT]) |-> !power_down_o[p])
			else $error("output enable did not leave power-down");

		chk_irq_async: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(q.port[p].irq_en && q.port[p].int_oe && armed[p] != 8'h00)
			|-> !(p == 0 ? sleep_or_irq_pin_port_a_o : sleep_or_irq_pin_port_b_o))
			else $error("enabled event did not pull the pin low");

		chk_pend_sticky: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(armed[p] != 8'h00) |=> ((q.port[p].pend & $past(armed[p])) == $past(armed[p])))
			else $error("pending bit not set by its event");

		chk_read_clears: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(rd_irq_status_and_mask[p] && armed[p] == 8'h00) |=> (q.port[p].pend == 8'h00))
			else $error("status read left bits pending");

		chk_masked_quiet: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(q.port[p].mask == 8'h00) |-> (q.port[p].pend == 8'h00 || $past(rd_irq_status_and_mask[p]) == 1'b0))
			else $error("masked source became pending");

		chk_ed_wakes: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(q.port[p].ed != ED_AWAKE && line_energy_i[p]) |=> !ed_low_power_o[p])
			else $error("line activity did not wake the port");

		chk_ed_pulses: assert property (
			@(posedge mclk_i) disable iff (!rstn_i)
			(q.port[p].ed == ED_SLEEP && q.port[p].ed_cnt == '0 && !ed_wake[p])
			|=> ed_tx_wake_o[p])
			else $error("no wake pulse after sleep interval");
	end

	// shared pins: driven only as interrupt output, pull-up always on
	assign sleep_or_irq_pin_port_a_oe_n_o = ~q.port[0].int_oe;
	assign sleep_or_irq_pin_port_b_oe_n_o = ~q.port[1].int_oe;
	assign sleep_or_irq_pin_port_a_o = ~(irq_active[0] & q.port[0].int_oe);
	assign sleep_or_irq_pin_port_b_o = ~(irq_active[1] & q.port[1].int_oe);
	assign sleep_or_irq_pin_port_a_pullup_o = 1'b1;
	assign sleep_or_irq_pin_port_b_pullup_o = 1'b1;
	assign mgmt_rdata_o = q.rdata;

	// ---------------------------------------------------------------
	// next state: registers, status, energy detect
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [15:0] rv;
		logic wr;
		logic [2:0] pg;
		rv = 16'h0000;
		wr = 1'b0;
		pg = PAGE_MAIN;
		d = q;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			pg = q.port[p].page;
			wr = mgmt_wr_i && sel[p];
			// writes are taken in power-down too
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_BASIC_MODE_CONTROL))
				d.port[p].basic_mode_control = mgmt_wdata_i;
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_IRQ_CONTROL))
			begin
				d.port[p].int_oe = mgmt_wdata_i[IRQ_CONTROL_OE_BIT];
				d.port[p].irq_en = mgmt_wdata_i[IRQ_CONTROL_EN_BIT];
			end
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_IRQ_STATUS_AND_MASK))
				d.port[p].mask = mgmt_wdata_i[7:0];
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_REGISTER_PAGE_SELECT))
				d.port[p].page = mgmt_wdata_i[2:0];
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_TENBASE_STATUS_CONTROL))
				d.port[p].tbs = mgmt_wdata_i;
			if (wr && reg_hit(mgmt_addr_i, pg, OFS_ENERGY_DETECT_CONTROL))
				d.port[p].ed_en = mgmt_wdata_i[ENERGY_DETECT_CONTROL_EN_BIT];

			// read clears everything, but a same-cycle event survives
			d.port[p].pend = (rd_irq_status_and_mask[p] ? PEND_RST : q.port[p].pend) | armed[p];

			// energy detect sleep and periodic transmitter wake
			unique case (q.port[p].ed)
				ED_AWAKE:
				begin
					if (ed_sleep[p])
					begin
						d.port[p].ed = ED_SLEEP;
						d.port[p].ed_cnt = WAKE_LOAD;
					end
				end
				ED_SLEEP:
				begin
					if (ed_wake[p])
						d.port[p].ed = ED_AWAKE;
					else if (q.port[p].ed_cnt == '0)
					begin
						d.port[p].ed = ED_PULSE;
						d.port[p].ed_cnt = PULSE_LOAD;
					end
					else
						d.port[p].ed_cnt = q.port[p].ed_cnt - 1'b1;
				end
				ED_PULSE:
				begin
					if (ed_wake[p])
						d.port[p].ed = ED_AWAKE;
					else if (q.port[p].ed_cnt == '0)
					begin
						d.port[p].ed = ED_SLEEP;
						d.port[p].ed_cnt = WAKE_LOAD;
					end
					else
						d.port[p].ed_cnt = q.port[p].ed_cnt - 1'b1;
				end
				default:
					d.port[p].ed = ED_AWAKE;
			endcase
		end

		// read data for the selected port; diagnostic page reads as zero except page select
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (sel[p])
			begin
				pg = q.port[p].page;
				if (reg_hit(mgmt_addr_i, pg, OFS_BASIC_MODE_CONTROL))
					rv = q.port[p].basic_mode_control;
				else if (reg_hit(mgmt_addr_i, pg, OFS_PHY_STATUS_SUMMARY))
				begin
					rv[PHY_STATUS_SUMMARY_LINK_BIT] = link_up_i[p];
					rv[PHY_STATUS_SUMMARY_SPD10_BIT] = speed10_i[p];
					rv[PHY_STATUS_SUMMARY_IRQ_BIT] = |q.port[p].pend;
					rv[PHY_STATUS_SUMMARY_POL_BIT] = pol_rep[p];
				end
				else if (reg_hit(mgmt_addr_i, pg, OFS_IRQ_CONTROL))
				begin
					rv[IRQ_CONTROL_OE_BIT] = q.port[p].int_oe;
					rv[IRQ_CONTROL_EN_BIT] = q.port[p].irq_en;
				end
				else if (reg_hit(mgmt_addr_i, pg, OFS_IRQ_STATUS_AND_MASK))
					rv = {q.port[p].pend, q.port[p].mask};
				else if (reg_hit(mgmt_addr_i, pg, OFS_REGISTER_PAGE_SELECT))
					rv[2:0] = q.port[p].page;
				else if (reg_hit(mgmt_addr_i, pg, OFS_TENBASE_STATUS_CONTROL))
				begin
					rv = q.port[p].tbs;
					rv[TBS_POL_BIT] = pol_rep[p];
				end
				else if (reg_hit(mgmt_addr_i, pg, OFS_ENERGY_DETECT_CONTROL))
					rv[ENERGY_DETECT_CONTROL_EN_BIT] = q.port[p].ed_en;
			end
		end
		if (mgmt_rd_i)
			d.rdata = rv;
	end

	// all state in one register; reset puts the pin in input mode, sources off
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				q.port[p] <= PORT_RST;
			q.rdata <= 16'h0000;
		end
		else
			q <= d;
	end

endmodule

//--- host_model.sv
`timescale 1ns/10ps
// host side of the management register port
module host_model
(
	// clock
	input wire logic mclk_i,
	// management requests
	output logic port_o,
	output logic [4:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] wdata_o
);
	// idle bus from time zero
	initial
	begin
		port_o = 1'b0;
		addr_o = 5'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 16'h0000;
	end

	// one write, strobe up for exactly one edge
	task automatic wr(input logic p, input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		port_o <= p;
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
	endtask

	// one read, data answers one cycle after the taking edge
	task automatic rd(input logic p, input logic [4:0] a);
		@(posedge mclk_i);
		port_o <= p;
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
	endtask
endmodule

//--- test_phy_pd_irq_core.sv
`timescale 1ns/10ps
// bench for the shared pin and interrupt block
module test_phy_pd_irq_core
	import phy_pd_pkg::*;
;
	logic mclk_i;
	logic rstn_i;
	logic [1:0] ext_low, link_up, speed10, an100, energy, nlp_p, nlp_n;
	logic [1:0][7:0] src;
	logic m_port, m_wr, m_rd;
	logic [4:0] m_addr;
	logic [15:0] m_wdata, rdata;
	logic pin_ai, pin_ao, oen_a, pu_a, pin_bi, pin_bo, oen_b, pu_b;
	logic [1:0] pd, edlp, edw, pinv;
	logic [15:0] expq[$];
	logic rd_seen = 1'b0;
	logic [7:0] m, s;
	int fail_count = 0;
	int n_compared = 0;
	int seed;

	// ---------------------------------------------------------------
	// wiring
	// ---------------------------------------------------------------
	// pin level from device drive, outside pull-down and weak pull-up
	assign pin_ai = oen_a ? (ext_low[0] ? 1'b0 : pu_a) : pin_ao;
	assign pin_bi = oen_b ? (ext_low[1] ? 1'b0 : pu_b) : pin_bo;

	host_model host_u (.mclk_i(mclk_i), .port_o(m_port), .addr_o(m_addr), .wr_o(m_wr),
		.rd_o(m_rd), .wdata_o(m_wdata));

	phy_pd_irq_core #(.ED_WAKE_CYCLES(20)) dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.mgmt_port_i(m_port), .mgmt_addr_i(m_addr), .mgmt_wr_i(m_wr), .mgmt_rd_i(m_rd),
		.mgmt_wdata_i(m_wdata), .mgmt_rdata_o(rdata),
		.sleep_or_irq_pin_port_a_i(pin_ai), .sleep_or_irq_pin_port_a_o(pin_ao),
		.sleep_or_irq_pin_port_a_oe_n_o(oen_a), .sleep_or_irq_pin_port_a_pullup_o(pu_a),
		.sleep_or_irq_pin_port_b_i(pin_bi), .sleep_or_irq_pin_port_b_o(pin_bo),
		.sleep_or_irq_pin_port_b_oe_n_o(oen_b), .sleep_or_irq_pin_port_b_pullup_o(pu_b),
		.link_up_i(link_up), .speed10_i(speed10), .an100_i(an100), .line_energy_i(energy),
		.nlp_pulse_i(nlp_p), .nlp_inverted_i(nlp_n), .irq_src_i(src), .power_down_o(pd),
		.ed_low_power_o(edlp), .ed_tx_wake_o(edw), .rx_pol_invert_o(pinv));

	// clock, 4 ns period
	initial
	begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	// ---------------------------------------------------------------
	// checking
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// note the expected word, then read
	task automatic rdx(input logic p, input logic [4:0] a, input logic [15:0] e);
		expq.push_back(e);
		host_u.rd(p, a);
	endtask

	// oldest note against each read answer
	always @(posedge mclk_i)
	begin
		if (rd_seen)
			chk("rdata", rdata, expq.pop_front());
		rd_seen <= m_rd;
	end

	// watchdog well beyond the expected run
	initial
	begin
		repeat (5000) @(posedge mclk_i);
		fail_count++;
		close_out();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial
	begin
		seed = 61;
		rstn_i = 1'b0;
		ext_low = 2'b10;
		link_up = 2'b00;
		speed10 = 2'b00;
		an100 = 2'b00;
		energy = 2'b11;
		nlp_p = 2'b00;
		nlp_n = 2'b00;
		src = '0;
		repeat (12) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 chk("pd", 16'(pd), 16'h0002);
		chk("oe_n", 16'({oen_b, oen_a}), 16'h0003);
		chk("pullup", 16'({pu_b, pu_a}), 16'h0003);
		rdx(1'b0, OFS_IRQ_CONTROL, 16'h0000);
		rdx(1'b1, OFS_IRQ_STATUS_AND_MASK, 16'h0000);
		host_u.wr(1'b1, OFS_IRQ_CONTROL, 16'h0001);
		@(posedge mclk_i);
		#1 chk("pd", 16'(pd), 16'h0000);
		chk("oe_n", 16'({oen_b, oen_a}), 16'h0001);
		// port a pulled low by an outside driver
		@(posedge mclk_i);
		ext_low <= 2'b01;
		repeat (3) @(posedge mclk_i);
		#1 chk("pd", 16'(pd), 16'h0001);
		@(posedge mclk_i);
		ext_low <= 2'b00;
		host_u.wr(1'b0, OFS_IRQ_CONTROL, 16'h0003);
		host_u.wr(1'b0, OFS_IRQ_STATUS_AND_MASK, 16'h0060);
		@(posedge mclk_i);
		src <= {8'hff, 8'h20};
		#1 chk("pin_a", 16'(pin_ao), 16'h0000);
		chk("pin_b", 16'(pin_bo), 16'h0001);
		@(posedge mclk_i);
		src <= '0;
		@(posedge mclk_i);
		rdx(1'b0, OFS_IRQ_STATUS_AND_MASK, 16'h2060);
		rdx(1'b1, OFS_IRQ_STATUS_AND_MASK, 16'h0000);
		#1 chk("pin_a", 16'(pin_ao), 16'h0001);
		// random masks and sources on port a
		repeat (4)
		begin
			m = 8'($random(seed));
			s = 8'($random(seed));
			host_u.wr(1'b0, OFS_IRQ_STATUS_AND_MASK, {8'h00, m});
			@(posedge mclk_i);
			src[0] <= s;
			@(posedge mclk_i);
			src[0] <= 8'h00;
			@(posedge mclk_i);
			rdx(1'b0, OFS_IRQ_STATUS_AND_MASK, {s & m, m});
		end
		// diagnostic page hides the main set
		host_u.wr(1'b0, OFS_REGISTER_PAGE_SELECT, 16'h0002);
		rdx(1'b0, OFS_IRQ_CONTROL, 16'h0000);
		rdx(1'b0, OFS_REGISTER_PAGE_SELECT, 16'h0002);
		host_u.wr(1'b0, OFS_REGISTER_PAGE_SELECT, 16'h0000);
		// three inverted link pulses
		repeat (3)
		begin
			@(posedge mclk_i);
			nlp_p <= 2'b01;
			nlp_n <= 2'b01;
			@(posedge mclk_i);
			nlp_p <= 2'b00;
		end
		@(posedge mclk_i);
		#1 chk("pol_inv", 16'(pinv), 16'h0001);
		rdx(1'b0, OFS_PHY_STATUS_SUMMARY, 16'h0000);
		an100 <= 2'b01;
		rdx(1'b0, OFS_PHY_STATUS_SUMMARY, 16'h1000);
		an100 <= 2'b00;
		speed10 <= 2'b01;
		link_up <= 2'b01;
		rdx(1'b0, OFS_PHY_STATUS_SUMMARY, 16'h1003);
		rdx(1'b0, OFS_TENBASE_STATUS_CONTROL, 16'h0010);
		rdx(1'b0, OFS_TENBASE_STATUS_CONTROL, 16'h0000);
		// three normal link pulses drop the correction
		nlp_n <= 2'b00;
		repeat (3)
		begin
			@(posedge mclk_i);
			nlp_p <= 2'b01;
			@(posedge mclk_i);
			nlp_p <= 2'b00;
		end
		@(posedge mclk_i);
		#1 chk("pol_inv", 16'(pinv), 16'h0000);
		// energy detect on port b
		host_u.wr(1'b1, OFS_ENERGY_DETECT_CONTROL, 16'h8000);
		@(posedge mclk_i);
		energy <= 2'b01;
		repeat (2) @(posedge mclk_i);
		#1 chk("ed_lp", 16'(edlp), 16'h0002);
		repeat (60) if (edw[1] !== 1'b1) @(posedge mclk_i) #1;
		chk("ed_wake", 16'(edw), 16'h0002);
		@(posedge mclk_i);
		energy <= 2'b11;
		repeat (2) @(posedge mclk_i);
		#1 chk("ed_lp", 16'(edlp), 16'h0000);
		repeat (4) @(posedge mclk_i);
		close_out();
	end
endmodule
